// File: hvcb_defs.vh
`ifndef HVCB_DEFS_VH
`define HVCB_DEFS_VH
// Command port: bit 3 = write strobe, bit 2 = read strobe, bits 1:0 = register select.
`define HVCB_CMD_WR_BIT      3
`define HVCB_CMD_RD_BIT      2
`define HVCB_SEL_CFG1        2'h1
`define HVCB_SEL_MON         2'h2
`define HVCB_SEL_STA         2'h3
`define HVCB_CFG1_RESET      8'h00
`define HVCB_CFG_TMON_BIT    6
`define HVCB_CFG_VSHORT_BIT  5
`define HVCB_CFG_SENSE_BIT   4
`define HVCB_CFG_REEN_BIT    3
`define HVCB_CFG_PASSIVE_BIT 2
`define HVCB_MON_WAKE_BIT    7
`define HVCB_MON_OVT_BIT     6
`define HVCB_MON_AUX_BIT     5
`define HVCB_MON_BUS_SC_BIT  2
`define HVCB_MON_AUX_SC_BIT  1
`define HVCB_MON_WAKE_SC_BIT 0
`define HVCB_STA_BUS_SC_BIT  0
`define HVCB_STA_AUX_SC_BIT  1
`define HVCB_STA_WAKE_SC_BIT 2
`define HVCB_STA_EDGE_BIT    3
`define HVCB_CLK_MHZ         50
`define HVCB_SC_FAST_US      20
`define HVCB_SC_SLOW_US      400
`define HVCB_SC_FAST_CYC     (`HVCB_SC_FAST_US * `HVCB_CLK_MHZ)
`define HVCB_SC_SLOW_CYC     (`HVCB_SC_SLOW_US * `HVCB_CLK_MHZ)
`endif

// File: hvcb_sync.v
`timescale 1ns/1ps
`default_nettype none
module hvcb_sync (
   input  wire mclk,
   input  wire sys_rst,
   input  wire din,
   output reg  dout_r
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // Level moves only once the second and third stages agree.
   always @(posedge mclk) begin
      if (sys_rst) begin
         s1_r   <= 1'b0;
         s2_r   <= 1'b0;
         s3_r   <= 1'b0;
         dout_r <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout_r <= s3_r;
         end
      end
   end
endmodule // hvcb_sync
`default_nettype wire

// File: hvcb_persist.v
`timescale 1ns/1ps
`default_nettype none
module hvcb_persist #(
   parameter [31:0] LIMIT = 32'd1000
) (
   input  wire mclk,
   input  wire sys_rst,
   input  wire level,
   output reg  event_r
);
   reg [31:0] cnt_r;
   // Pulses once when level has held longer than LIMIT cycles.
   always @(posedge mclk) begin
      if (sys_rst) begin
         cnt_r   <= 32'h0;
         event_r <= 1'b0;
      end else begin
         event_r <= 1'b0;
         if (!level) begin
            cnt_r <= 32'h0;
         end else if (cnt_r <= LIMIT) begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == LIMIT) begin
               event_r <= 1'b1;
            end
         end
      end
   end
endmodule // hvcb_persist
`default_nettype wire

// File: hvcb_top.v
`timescale 1ns/1ps
`default_nettype none
`include "hvcb_defs.vh"
// Behaviour
// R01: Bit 6 powers temperature monitor to ADC.
// R02: Bit 5 shorts voltage channel input.
// R03: Bit 4 enables wake and aux sensing.
// R04: Sensing raises interrupt on any edge.
// R05: Sensing shows wake bit7, aux bit5.
// R06: Bit 3 re-enables short-disabled pins.
// R07: Shorts count after 20us/400us persistence.
// R08: Bit 3 restores thermally disabled pins.
// R09: Short interrupt clears only via bit 3.
// R10: Bit 3 self-clears after write.
// R11: Passive mode bus short raises interrupt.
// R12: Passive mode flags but keeps driver; a wake short still clears wake_drv_enable_r.
// R13: Active mode flags and disables pin.
// R14: Reset zero; access via command/data ports.
module hvcb_top #(
   parameter [31:0] SC_FAST_CYC = `HVCB_SC_FAST_CYC,
   parameter [31:0] SC_SLOW_CYC = `HVCB_SC_SLOW_CYC
) (
   input  wire       mclk,
   input  wire       sys_rst,
   input  wire [3:0] hv_command_port,
   input  wire       hv_cmd_valid,
   input  wire [7:0] hv_data_port_wdata,
   output reg  [7:0] hv_data_port_rdata_r,
   input  wire       irq_enable_mask,
   input  wire       wake_pin,
   input  wire       aux_hv_io_pin,
   input  wire       bus_sc_detect,
   input  wire       aux_sc_detect,
   input  wire       wake_sc_detect,
   input  wire       thermal_event,
   output reg        tmon_enable_r,
   output reg        vchan_short_r,
   output reg        sense_enable_r,
   output reg        bus_drv_enable_r,
   output reg        aux_drv_enable_r,
   output reg        wake_drv_enable_r,
   output reg        hv_irq_line_r
);
   // ****************************************************************
   // Pin synchronisers and short persistence filters.
   // ****************************************************************
   wire wake_s;
   wire aux_s;
   wire bus_sc_s;
   wire aux_sc_s;
   wire wake_sc_s;
   wire therm_s;
   wire bus_sc_ev;
   wire aux_sc_ev;
   wire wake_sc_ev;
   hvcb_sync u_sw (.mclk(mclk), .sys_rst(sys_rst), .din(wake_pin), .dout_r(wake_s));
   hvcb_sync u_sa (.mclk(mclk), .sys_rst(sys_rst), .din(aux_hv_io_pin), .dout_r(aux_s));
   hvcb_sync u_sb (.mclk(mclk), .sys_rst(sys_rst), .din(bus_sc_detect), .dout_r(bus_sc_s));
   hvcb_sync u_sx (.mclk(mclk), .sys_rst(sys_rst), .din(aux_sc_detect), .dout_r(aux_sc_s));
   hvcb_sync u_sy (.mclk(mclk), .sys_rst(sys_rst), .din(wake_sc_detect), .dout_r(wake_sc_s));
   hvcb_sync u_st (.mclk(mclk), .sys_rst(sys_rst), .din(thermal_event), .dout_r(therm_s));
   hvcb_persist #(.LIMIT(SC_FAST_CYC)) u_pb ( // [R07]
      .mclk(mclk), .sys_rst(sys_rst), .level(bus_sc_s), .event_r(bus_sc_ev));
   hvcb_persist #(.LIMIT(SC_FAST_CYC)) u_pa ( // [R07]
      .mclk(mclk), .sys_rst(sys_rst), .level(aux_sc_s), .event_r(aux_sc_ev));
   hvcb_persist #(.LIMIT(SC_SLOW_CYC)) u_pw ( // [R07]
      .mclk(mclk), .sys_rst(sys_rst), .level(wake_sc_s), .event_r(wake_sc_ev));

   // ****************************************************************
   // Configuration register and command decode.
   // ****************************************************************
   reg  [7:0] cfg_r;
   reg  [3:0] sta_r;
   reg        ovt_r;
   reg        wake_d_r;
   reg        aux_d_r;
   wire       wr_cmd = hv_cmd_valid & hv_command_port[`HVCB_CMD_WR_BIT];
   wire       rd_cmd = hv_cmd_valid & hv_command_port[`HVCB_CMD_RD_BIT];
   wire       cfg_wr = wr_cmd & (hv_command_port[1:0] == `HVCB_SEL_CFG1);
   wire       reen   = cfg_r[`HVCB_CFG_REEN_BIT];
   wire       sense  = cfg_r[`HVCB_CFG_SENSE_BIT];
   wire       passive = cfg_r[`HVCB_CFG_PASSIVE_BIT];
   wire       edge_ev = sense & ((wake_s ^ wake_d_r) | (aux_s ^ aux_d_r)); // [R04]
   wire [7:0] mon;
   assign mon = {sense & wake_s, ovt_r, sense & aux_s, 2'b00, // [R05]
                 sta_r[`HVCB_STA_BUS_SC_BIT], sta_r[`HVCB_STA_AUX_SC_BIT],
                 sta_r[`HVCB_STA_WAKE_SC_BIT]};

   always @(posedge mclk) begin
      if (sys_rst) begin
         cfg_r <= `HVCB_CFG1_RESET; // [R14]
      end else if (cfg_wr) begin
         cfg_r <= hv_data_port_wdata; // [R14]
      end else begin
         cfg_r[`HVCB_CFG_REEN_BIT] <= 1'b0; // [R10]
      end
   end

   // ****************************************************************
   // Status flags, driver enables and read data.
   // ****************************************************************
   always @(posedge mclk) begin
      if (sys_rst) begin
         sta_r             <= 4'h0;
         ovt_r             <= 1'b0;
         wake_d_r          <= 1'b0;
         aux_d_r           <= 1'b0;
         bus_drv_enable_r  <= 1'b1;
         aux_drv_enable_r  <= 1'b1;
         wake_drv_enable_r <= 1'b1;
         hv_data_port_rdata_r <= 8'h00;
         tmon_enable_r     <= 1'b0;
         vchan_short_r     <= 1'b0;
         sense_enable_r    <= 1'b0;
         hv_irq_line_r     <= 1'b0;
      end else begin
         wake_d_r <= wake_s;
         aux_d_r  <= aux_s;
         tmon_enable_r  <= cfg_r[`HVCB_CFG_TMON_BIT]; // [R01]
         vchan_short_r  <= cfg_r[`HVCB_CFG_VSHORT_BIT]; // [R02]
         sense_enable_r <= sense; // [R03]
         if (reen) begin
            // Clear first; a fresh event in this cycle below still wins.
            sta_r[`HVCB_STA_BUS_SC_BIT]  <= 1'b0; // [R09]
            sta_r[`HVCB_STA_AUX_SC_BIT]  <= 1'b0; // [R09]
            sta_r[`HVCB_STA_WAKE_SC_BIT] <= 1'b0; // [R09]
            ovt_r             <= 1'b0;
            bus_drv_enable_r  <= 1'b1; // [R06]
            aux_drv_enable_r  <= 1'b1; // [R06] [R08]
            wake_drv_enable_r <= 1'b1; // [R06] [R08]
         end
         if (rd_cmd & (hv_command_port[1:0] == `HVCB_SEL_STA)) begin
            sta_r[`HVCB_STA_EDGE_BIT] <= 1'b0;
         end
         if (edge_ev) begin
            sta_r[`HVCB_STA_EDGE_BIT] <= 1'b1; // [R04]
         end
         if (bus_sc_ev) begin
            sta_r[`HVCB_STA_BUS_SC_BIT] <= 1'b1; // [R12] [R13]
            if (!passive) begin
               bus_drv_enable_r <= 1'b0; // [R13]
            end
         end
         if (aux_sc_ev) begin
            sta_r[`HVCB_STA_AUX_SC_BIT] <= 1'b1; // [R12]
            if (!passive) begin
               aux_drv_enable_r <= 1'b0;
            end
         end
         if (wake_sc_ev) begin
            sta_r[`HVCB_STA_WAKE_SC_BIT] <= 1'b1;
            wake_drv_enable_r <= 1'b0;
         end
         if (therm_s) begin
            ovt_r             <= 1'b1;
            aux_drv_enable_r  <= 1'b0;
            wake_drv_enable_r <= 1'b0;
         end
         hv_irq_line_r <= irq_enable_mask & (|sta_r); // [R11] [R13]
         if (rd_cmd) begin
            case (hv_command_port[1:0])
               `HVCB_SEL_CFG1: hv_data_port_rdata_r <= cfg_r; // [R14]
               `HVCB_SEL_MON:  hv_data_port_rdata_r <= mon;
               `HVCB_SEL_STA:  hv_data_port_rdata_r <= {4'h0, sta_r};
               default:        hv_data_port_rdata_r <= 8'h00;
            endcase
         end
      end
   end
endmodule // hvcb_top
`default_nettype wire

// File: hvcb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module hvcb_asserts (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic [3:0] hv_command_port,
   input wire logic       hv_cmd_valid,
   input wire logic [7:0] hv_data_port_wdata,
   input wire logic [7:0] hv_data_port_rdata_r,
   input wire logic       irq_enable_mask,
   input wire logic       bus_sc_detect,
   input wire logic       tmon_enable_r,
   input wire logic       vchan_short_r,
   input wire logic       sense_enable_r,
   input wire logic       bus_drv_enable_r,
   input wire logic       hv_irq_line_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [7:0] wd_r;
   wire wr = hv_cmd_valid && hv_command_port[3] && hv_command_port[1:0] == 2'h1;
   wire rc = hv_cmd_valid && hv_command_port == 4'h5;
   always_ff @(posedge mclk) if (wr) wd_r <= hv_data_port_wdata;
   sequence wr_alone; wr ##1 !hv_cmd_valid; endsequence
   sequence bus_quiet; !bus_sc_detect [*8]; endsequence
   a_tmon_follow: assert property (wr_alone |=> tmon_enable_r == wd_r[6])
      else $error("tmon");
   a_vshort_follow: assert property (wr_alone |=> vchan_short_r == wd_r[5])
      else $error("vshort");
   a_sense_follow: assert property (wr_alone |=> sense_enable_r == wd_r[4])
      else $error("sense");
   a_strobe_clear: assert property (wr_alone ##1 rc |=> hv_data_port_rdata_r == (wd_r & 8'hf7))
      else $error("strobe");
   a_bus_off_cause: assert property ($fell(bus_drv_enable_r) |-> $past(bus_sc_detect, 8))
      else $error("bus off");
   a_reen_restore: assert property (bus_quiet ##0 (wr && hv_data_port_wdata[3]) |-> ##3 bus_drv_enable_r)
      else $error("reen");
   a_irq_masked: assert property (!irq_enable_mask |=> !hv_irq_line_r)
      else $error("mask");
   a_sel_zero: assert property (hv_cmd_valid && hv_command_port == 4'h4 |=> hv_data_port_rdata_r == 8'h00)
      else $error("sel0");
endmodule // hvcb_asserts
bind hvcb_top hvcb_asserts hvcb_asserts_inst (.*);
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       mclk = 1'h0, sys_rst = 1'h1, hv_cmd_valid = 1'h0, irq_enable_mask = 1'h0;
   logic       wake_pin = 1'h0, aux_hv_io_pin = 1'h0, bus_sc_detect = 1'h0, aux_sc_detect = 1'h0;
   logic       wake_sc_detect = 1'h0, thermal_event = 1'h0;
   logic [3:0] hv_command_port = 4'h0;
   logic [7:0] hv_data_port_wdata = 8'h00, d;
   wire  [7:0] hv_data_port_rdata_r;
   wire        tmon_enable_r, vchan_short_r, sense_enable_r, hv_irq_line_r;
   wire        bus_drv_enable_r, aux_drv_enable_r, wake_drv_enable_r;
   integer     seed = 56342, mismatches = 0, total_checks = 0, cyc = 0, i;
   hvcb_top #(.SC_FAST_CYC(32'd8), .SC_SLOW_CYC(32'd16)) hvcb_top_inst (
      .mclk(mclk), .sys_rst(sys_rst), .hv_command_port(hv_command_port),
      .hv_cmd_valid(hv_cmd_valid), .hv_data_port_wdata(hv_data_port_wdata),
      .hv_data_port_rdata_r(hv_data_port_rdata_r), .irq_enable_mask(irq_enable_mask),
      .wake_pin(wake_pin), .aux_hv_io_pin(aux_hv_io_pin), .bus_sc_detect(bus_sc_detect),
      .aux_sc_detect(aux_sc_detect), .wake_sc_detect(wake_sc_detect),
      .thermal_event(thermal_event), .tmon_enable_r(tmon_enable_r),
      .vchan_short_r(vchan_short_r), .sense_enable_r(sense_enable_r),
      .bus_drv_enable_r(bus_drv_enable_r), .aux_drv_enable_r(aux_drv_enable_r),
      .wake_drv_enable_r(wake_drv_enable_r), .hv_irq_line_r(hv_irq_line_r));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         final_report;
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function logic [7:0] cfg_exp(input logic [7:0] v);
      cfg_exp = v & 8'hf7;
   endfunction
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task tk(input integer n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task cmd(input logic [3:0] c, input logic [7:0] w);
      tk(1);
      hv_cmd_valid = 1'h1;
      hv_command_port = c;
      hv_data_port_wdata = w;
      tk(1);
      hv_cmd_valid = 1'h0;
   endtask
   task rd(input logic [1:0] s, input logic [7:0] e, input string n);
      cmd({2'h1, s}, 8'h00);
      chk(n, e, hv_data_port_rdata_r);
   endtask
   initial begin
      tk(16);
      sys_rst = 1'h0;
      rd(2'h1, 8'h00, "cfg rst");
      rd(2'h0, 8'h00, "sel0");
      for (i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h7c : $random(seed) & 8'hfc;
         cmd(4'h9, d);
         rd(2'h1, cfg_exp(d), "cfg");
         chk("tmon", d[6], tmon_enable_r);
         chk("vshort", d[5], vchan_short_r);
         chk("sense", d[4], sense_enable_r);
      end
      cmd(4'h9, 8'h18);
      rd(2'h3, 8'h00, "sta clr");
      irq_enable_mask = 1'h1;
      wake_pin = 1'h1;
      tk(8);
      chk("edge irq", 1, hv_irq_line_r);
      rd(2'h2, 8'h80, "mon wake");
      rd(2'h3, 8'h08, "sta edge");
      wake_pin = 1'h0;
      aux_hv_io_pin = 1'h1;
      tk(8);
      chk("edge irq2", 1, hv_irq_line_r);
      rd(2'h2, 8'h20, "mon aux");
      cmd(4'h9, 8'h08);
      bus_sc_detect = 1'h1;
      tk(4);
      bus_sc_detect = 1'h0;
      tk(10);
      chk("short glitch", 1, bus_drv_enable_r);
      rd(2'h3, 8'h08, "sta idle");
      bus_sc_detect = 1'h1;
      tk(20);
      chk("active off", 0, bus_drv_enable_r);
      chk("active irq", 1, hv_irq_line_r);
      bus_sc_detect = 1'h0;
      tk(12);
      rd(2'h3, 8'h01, "sta held");
      cmd(4'h9, 8'h08);
      tk(2);
      chk("reen", 1, bus_drv_enable_r);
      rd(2'h3, 8'h00, "sta reen");
      cmd(4'h9, 8'h04);
      irq_enable_mask = 1'h0;
      bus_sc_detect = 1'h1;
      tk(20);
      chk("passive drv", 1, bus_drv_enable_r);
      chk("masked irq", 0, hv_irq_line_r);
      irq_enable_mask = 1'h1;
      tk(2);
      chk("passive irq", 1, hv_irq_line_r);
      rd(2'h3, 8'h01, "sta pas");
      bus_sc_detect = 1'h0;
      wake_sc_detect = 1'h1;
      tk(10);
      chk("wake short", 1, wake_drv_enable_r);
      tk(15);
      chk("wake off", 0, wake_drv_enable_r);
      wake_sc_detect = 1'h0;
      thermal_event = 1'h1;
      tk(8);
      thermal_event = 1'h0;
      chk("therm aux", 0, aux_drv_enable_r);
      tk(8);
      cmd(4'h9, 8'h0c);
      tk(2);
      chk("aux back", 1, aux_drv_enable_r);
      chk("wake back", 1, wake_drv_enable_r);
      rd(2'h3, 8'h00, "sta end");
      final_report;
   end
endmodule // testbench
`default_nettype wire
